// file: src/mdec_pkg.sv
package mdec_pkg;

  // Oversampling ratio of the link clock against the bit rate
  localparam int unsigned OVERSAMPLE_RATIO = 16;
  // Delay of three quarters of a bit, in link clock cycles
  localparam int unsigned DELAY_CYCLES     = (OVERSAMPLE_RATIO * 3) / 4;
  localparam int unsigned DELAY_WIDTH      = 4;
  localparam logic [DELAY_WIDTH-1:0] DELAY_LAST  = 4'(DELAY_CYCLES - 1);
  localparam logic [DELAY_WIDTH-1:0] DELAY_RESET = 4'h0;

  // Period settings of the polarity toggle counter
  localparam logic TOGGLE_PERIOD_START = 1'h0;
  localparam logic TOGGLE_PERIOD_RUN   = 1'h1;

  typedef enum logic [1:0] {
    MDEC_IDLE  = 2'b00,
    MDEC_START = 2'b01,
    MDEC_RUN   = 2'b10
  } mdec_init_t;

  typedef struct packed {
    logic                   lineMeta;
    logic                   lineSync;
    logic                   enableMeta;
    logic                   enableSync;
    mdec_init_t             initState;
    logic                   togglePeriod;
    logic [DELAY_WIDTH-1:0] delayCount;
    logic                   compareOutput;
    logic                   terminalCountOut;
    logic                   polarity;
    logic                   clockOut;
    logic                   bitToggle;
  } mdec_link_t;

  typedef struct packed {
    logic dataMeta;
    logic dataSync;
    logic clockMeta;
    logic clockSync;
    logic toggleMeta;
    logic toggleSync;
    logic toggleLast;
    logic bitStrobe;
  } mdec_sys_t;

  localparam mdec_link_t LINK_RESET = '{
    lineMeta: 1'h0, lineSync: 1'h0, enableMeta: 1'h0, enableSync: 1'h0,
    initState: MDEC_IDLE, togglePeriod: TOGGLE_PERIOD_START,
    delayCount: DELAY_RESET, compareOutput: 1'h0, terminalCountOut: 1'h0,
    polarity: 1'h0, clockOut: 1'h0, bitToggle: 1'h0};

  localparam mdec_sys_t SYS_RESET = '{
    dataMeta: 1'h0, dataSync: 1'h0, clockMeta: 1'h0, clockSync: 1'h0,
    toggleMeta: 1'h0, toggleSync: 1'h0, toggleLast: 1'h0, bitStrobe: 1'h0};

endpackage : mdec_pkg

// file: src/mdec_manchester_decoder.sv
// Operation
// R1: Every bit has a mid-bit edge; rising means zero, falling means one.
// R2: Transmitter adds boundary edges so each bit keeps its mid-bit edge.
// R3: Each mid-bit edge starts a three-quarter-bit delay; its end samples next bit.
// R4: Sampled one sets the polarity flip, sampled zero clears it.
// R5: Data out is the polarity flip; clock out is line XOR polarity flip.
// R6: A storage element captures the line when the delay expires.
// R7: The delay counter is triggered by the XOR output.
// R8: Storage is a conditional toggle enabled by the XOR output.
// R9: Delay counter enable is XOR output OR its own compare output.
// R10: Polarity updates on terminal count; XOR drops a cycle before compare.
// R11: Counter clock is at least four times the bit rate; sixteen used.
// R12: Delay settings depend only on oversampling ratio, not on bit rate.
// R13: Counter clock runs at sixteen times the serial bit rate.
// R14: Toggle counter starts with period zero, then switches to one.
// R15: First edge is taken as mid-bit; realigns on first one-zero or zero-one pair.
// R16: Idle high with first bit zero aligns from the first one bit.
// R17: Enabling mid-packet realigns automatically by the same mechanism.
// R18: Transmitter starts each message with a bit matching the idle level.
// R19: Or the transmitter sends a zero-one or one-zero preamble.
// R20: Terminal count comes twelve oversampling clocks after the trigger.
`timescale 1ns/10ps
`default_nettype none

module mdec_manchester_decoder (
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic oversampleClock,
  input  wire logic lineIn,
  input  wire logic rxEnable,
  output var  logic recoveredDataOut,
  output var  logic recoveredClockOut,
  output var  logic bitStrobe
);
  import mdec_pkg::*;

  mdec_link_t link;
  mdec_link_t next_link;
  mdec_sys_t  sys;
  mdec_sys_t  next_sys;

  logic xorOut;
  logic delayEnable;

  // Link side runs on the oversampling clock itself
  always_comb begin
    next_link            = link;
    next_link.lineMeta   = lineIn;
    next_link.lineSync   = link.lineMeta;
    next_link.enableMeta = rxEnable;
    next_link.enableSync = link.enableMeta;
    // Rising XOR at every aligned mid-bit edge, whatever the bit value
    xorOut               = link.lineSync ^ link.polarity; // R1 R5 R7
    delayEnable          = xorOut | link.compareOutput; // R9
    unique case (link.initState)
      MDEC_IDLE: begin
        next_link.togglePeriod     = TOGGLE_PERIOD_START;
        next_link.delayCount       = DELAY_RESET;
        next_link.compareOutput    = 1'h0;
        next_link.terminalCountOut = 1'h0;
        next_link.polarity         = 1'h0;
        if (link.enableSync) begin
          next_link.initState = MDEC_START;
        end
      end
      MDEC_START: begin
        // Period zero holds the toggle output so startup begins clean
        next_link.togglePeriod = TOGGLE_PERIOD_RUN; // R14
        next_link.initState    = MDEC_RUN;
      end
      MDEC_RUN: begin
        if (link.terminalCountOut) begin
          // Compare drops here, one cycle after the XOR term fell
          next_link.terminalCountOut = 1'h0; // R10
          next_link.compareOutput    = 1'h0;
          next_link.delayCount       = DELAY_RESET;
        end else if (delayEnable) begin
          next_link.compareOutput = 1'h1; // R9
          // Count fixed by the ratio only; bit rate follows the link clock
          if (link.delayCount == DELAY_LAST) begin // R3 R20 R12 R11 R13
            next_link.delayCount       = DELAY_RESET;
            next_link.terminalCountOut = 1'h1;
            next_link.bitToggle        = ~link.bitToggle;
            // Toggle only when the sampled bit differs from the held one
            if (xorOut && link.togglePeriod == TOGGLE_PERIOD_RUN) begin // R8 R6
              next_link.polarity = ~link.polarity; // R4 R10
            end
          end else begin
            next_link.delayCount = link.delayCount + 4'h1; // R7
          end
        end
        // No lock state: any bit pair without a boundary edge realigns
        if (!link.enableSync) begin // R15 R16 R17
          next_link.initState = MDEC_IDLE;
        end
      end
      default: begin
        next_link.initState = MDEC_IDLE;
      end
    endcase
    // Registered so the crossing sees a glitch-free level
    next_link.clockOut = (link.lineSync ^ link.polarity) & (link.initState == MDEC_RUN); // R5
  end

  always_ff @(posedge oversampleClock or negedge reset_n) begin
    if (!reset_n) begin
      link <= LINK_RESET;
    end else begin
      link <= next_link;
    end
  end

  // System side: levels through two flops, bit event as a toggle
  always_comb begin
    next_sys            = sys;
    next_sys.dataMeta   = link.polarity;
    next_sys.dataSync   = sys.dataMeta;
    next_sys.clockMeta  = link.clockOut;
    next_sys.clockSync  = sys.clockMeta;
    next_sys.toggleMeta = link.bitToggle;
    next_sys.toggleSync = sys.toggleMeta;
    next_sys.toggleLast = sys.toggleSync;
    next_sys.bitStrobe  = sys.toggleSync ^ sys.toggleLast;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sys <= SYS_RESET;
    end else begin
      sys <= next_sys;
    end
  end

  assign recoveredDataOut  = sys.dataSync; // R5
  assign recoveredClockOut = sys.clockSync; // R5
  assign bitStrobe         = sys.bitStrobe;

endmodule : mdec_manchester_decoder

`default_nettype wire

// file: tb/mdec_checker.sv
`timescale 1ns/10ps
`default_nettype none
module mdec_checker (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic oversampleClock,
  input wire logic lineIn,
  input wire logic rxEnable,
  input wire logic recoveredDataOut,
  input wire logic recoveredClockOut,
  input wire logic bitStrobe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  strobe_width_a: assert property (bitStrobe |=> !bitStrobe [*3]) else $error("wide strobe");
  reset_quiet_a: assert property ($rose(reset_n) |-> !recoveredDataOut && !bitStrobe)
    else $error("busy at reset");
  enable_start_a: assert property ($rose(rxEnable) |-> !bitStrobe [*4]) else $error("early");
  idle_quiet_a: assert property (!rxEnable [*8] |-> !recoveredDataOut && !bitStrobe)
    else $error("active while off");
  clock_xor_a: assert property (
    (rxEnable && $stable(lineIn) && $stable(recoveredDataOut)) [*7]
    |-> recoveredClockOut == (lineIn ^ recoveredDataOut)) else $error("clock not xor");
  quiet_line_a: assert property (
    $stable(lineIn) [*8] ##1 $stable(lineIn) [*6] |-> !bitStrobe) else $error("stray strobe");
  edge_strobe_a: assert property (
    rxEnable [*8] ##0 $changed(lineIn) |-> ##[2:12] bitStrobe) else $error("no strobe");
  data_strobe_a: assert property (
    rxEnable [*8] ##0 $changed(recoveredDataOut) |-> (##[0:2] bitStrobe) or $past(bitStrobe))
    else $error("data moved alone");
endmodule : mdec_checker
bind mdec_manchester_decoder mdec_checker i_mdec_checker (.mclk, .reset_n, .oversampleClock,
  .lineIn, .rxEnable, .recoveredDataOut, .recoveredClockOut, .bitStrobe);
`default_nettype wire

// file: tb/mdec_encoder_model.sv
`timescale 1ns/10ps
`default_nettype none
module mdec_encoder_model (
  input  wire logic oversampleClock,
  output var  logic lineOut
);
  // Half bit is 8 link clocks; line rests at idle between frames
  task automatic send(input logic idle, input logic [15:0] bits, input int n);
    lineOut = idle;
    repeat (16) @(negedge oversampleClock);
    for (int i = n - 1; i >= 0; i--) begin
      lineOut = bits[i];
      repeat (8) @(negedge oversampleClock);
      lineOut = ~bits[i];
      repeat (8) @(negedge oversampleClock);
    end
    lineOut = idle;
    repeat (48) @(negedge oversampleClock);
  endtask : send
  initial lineOut = 1'h0;
endmodule : mdec_encoder_model
`default_nettype wire

// file: tb/mdec_manchester_decoder_bench.sv
`timescale 1ns/10ps
`default_nettype none
module mdec_manchester_decoder_bench;
  logic mclk = 1'h0, oversampleClock = 1'h0, reset_n = 1'h0, rxEnable = 1'h0, sLast = 1'h0;
  logic lineIn, recoveredDataOut, recoveredClockOut, bitStrobe;
  logic got [0:63];
  int   nGot = 0, n_mismatch = 0, total_checks = 0, cycles = 0;
  always #25 mclk = ~mclk;
  always #7.5 oversampleClock = ~oversampleClock;
  mdec_manchester_decoder i_mdec_manchester_decoder (.mclk, .reset_n, .oversampleClock,
    .lineIn, .rxEnable, .recoveredDataOut, .recoveredClockOut, .bitStrobe);
  mdec_encoder_model i_mdec_encoder_model (.oversampleClock, .lineOut(lineIn));
  // Data is taken one cycle after the strobe; it already settles one cycle before the strobe
  always @(posedge mclk) begin
    sLast <= bitStrobe;
    cycles <= cycles + 1;
    if (sLast) begin
      got[nGot] <= recoveredDataOut;
      nGot <= nGot + 1;
    end
    if (cycles == 1000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic check(input string what, input logic exp, input logic seen);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %b seen %b", what, exp, seen);
    end
  endtask : check
  // Last strobe samples the tail, so bit j sits j+2 back
  task automatic run_frame(input logic idle, input logic [15:0] b, input int n, input int k);
    int nStart;
    nStart = nGot;
    i_mdec_encoder_model.send(idle, b, n);
    check("strobes", 1'h1, (nGot - nStart) > k);
    check("data idle", idle, recoveredDataOut);
    check("clock idle", 1'h0, recoveredClockOut);
    for (int j = 0; j < k; j++) begin
      check("bit", b[j], got[nGot-2-j]);
    end
    $display("frame done");
  endtask : run_frame
  task automatic aligned_start;
    run_frame(1'h0, 16'h005A, 8, 7);
  endtask : aligned_start
  task automatic idle_high_start;
    run_frame(1'h1, 16'h001A, 8, 4);
  endtask : idle_high_start
  task automatic late_enable;
    rxEnable = 1'h0;
    repeat (20) @(negedge mclk);
    fork
      run_frame(1'h0, 16'h5A3C, 16, 6);
      begin
        repeat (24) @(negedge mclk);
        rxEnable = 1'h1;
      end
    join
  endtask : late_enable
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (16) @(negedge mclk);
    reset_n = 1'h1;
    @(negedge mclk);
    rxEnable = 1'h1;
    aligned_start();
    idle_high_start();
    late_enable();
    wrap_up();
  end
endmodule : mdec_manchester_decoder_bench
`default_nettype wire
